// ==== rtl/pasl_pkg.sv ====
/*
 * Shared constants for the port analog select and output latch block.
 * Assumes a 32-bit AXI4-Lite register bus with each register in one aligned word.
 */
// Summary of operation
// - Port A select bit zero routes that pin to port logic or digital functions.
// - Select bit one makes the pin analog and blocks its digital input buffer.
// - Port A select bits 7, 6 and 4 are absent and always read zero.
// - Implemented port A select bits become one on every reset.
// - Writes to the port E data address land in the 8-bit output latch.
// - Reads of the port E data address return the live pin levels, with analog-selected pins reading zero.
// - The port E latch powers up unknown and survives all later resets.
// - Port E select bits 2 to 0 act per pin like port A and reset to one.
package pasl_pkg;

	// Byte offsets of the registers.
	localparam logic [7:0] PASL_OFF_ANA_A  = 8'h00;
	localparam logic [7:0] PASL_OFF_PA_PIN = 8'h04;
	localparam logic [7:0] PASL_OFF_PE_PIN = 8'h08;
	localparam logic [7:0] PASL_OFF_PE_LAT = 8'h0c;
	localparam logic [7:0] PASL_OFF_ANA_E  = 8'h10;
	localparam logic [7:0] PASL_OFF_DIR_E  = 8'h14;

	// Implemented bits and values after reset.
	localparam logic [7:0] PASL_ANA_A_MASK = 8'h2f;
	localparam logic [7:0] PASL_ANA_E_MASK = 8'h07;
	localparam logic [7:0] PASL_ANA_A_RST  = 8'h2f;
	localparam logic [7:0] PASL_ANA_E_RST  = 8'h07;
	localparam logic [7:0] PASL_DIR_E_RST  = 8'hff;

	// AXI response codes.
	localparam logic [1:0] PASL_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PASL_RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/pasl_regbus_if.sv ====
/*
 * Carrier between the bus slave and the register logic.
 * Assumes the slave issues at most one write strobe per cycle.
 */
interface pasl_regbus_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_ok;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;

	modport slave (
		output wr_en,
		output wr_addr,
		output wr_data,
		output wr_strb,
		output rd_addr,
		input  wr_ok,
		input  rd_data,
		input  rd_ok
	);

	modport regs (
		input  wr_en,
		input  wr_addr,
		input  wr_data,
		input  wr_strb,
		input  rd_addr,
		output wr_ok,
		output rd_data,
		output rd_ok
	);
endinterface

// ==== rtl/pasl_axil_slave.sv ====
/*
 * AXI4-Lite slave front end: holds address and data, strobes one write, answers reads.
 * Assumes the register side decodes addresses and answers reads combinationally.
 */
module pasl_axil_slave (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Write address and data.
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	// Write response.
	output logic             bvalid_o,
	input  wire logic        bready_i,
	output logic [1:0]       bresp_o,
	// Read address and data.
	input  wire logic        arvalid_i,
	output logic             arready_o,
	input  wire logic [7:0]  araddr_i,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	// Register side.
	pasl_regbus_if.slave     bus
);

	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rd_pend_reg;
	logic [7:0]  araddr_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;

	// Nothing new is taken while a response waits, so one write and one read stay in flight.
	assign awready_o    = !aw_held_reg && !bvalid_reg;
	assign wready_o     = !w_held_reg && !bvalid_reg;
	assign arready_o    = !rd_pend_reg && !rvalid_reg;
	assign bvalid_o     = bvalid_reg;
	assign bresp_o      = bresp_reg;
	assign rvalid_o     = rvalid_reg;
	assign rdata_o      = rdata_reg;
	assign rresp_o      = rresp_reg;
	assign bus.wr_en    = aw_held_reg && w_held_reg;
	assign bus.wr_addr  = awaddr_reg;
	assign bus.wr_data  = wdata_reg;
	assign bus.wr_strb  = wstrb_reg;
	assign bus.rd_addr  = araddr_reg;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= 8'h00;
		end else if (awvalid_i && awready_o) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= awaddr_i;
		end else if (bus.wr_en) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
		end else if (wvalid_i && wready_o) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= wdata_i;
			wstrb_reg  <= wstrb_i;
		end else if (bus.wr_en) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= pasl_pkg::PASL_RESP_OKAY;
		end else if (bus.wr_en) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= bus.wr_ok ? pasl_pkg::PASL_RESP_OKAY : pasl_pkg::PASL_RESP_SLVERR;
		end else if (bready_i) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_pend_reg <= 1'b0;
			araddr_reg  <= 8'h00;
		end else if (arvalid_i && arready_o) begin
			rd_pend_reg <= 1'b1;
			araddr_reg  <= araddr_i;
		end else begin
			rd_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= pasl_pkg::PASL_RESP_OKAY;
		end else if (rd_pend_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= bus.rd_data;
			rresp_reg  <= bus.rd_ok ? pasl_pkg::PASL_RESP_OKAY : pasl_pkg::PASL_RESP_SLVERR;
		end else if (rready_i) begin
			rvalid_reg <= 1'b0;
		end
	end

	sequence write_taken_s;
		aw_held_reg && w_held_reg;
	endsequence

	write_resp_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		write_taken_s |=> bvalid_o && !aw_held_reg && !w_held_reg)
		else $error("Write response did not follow the held write.");

	read_resp_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		arvalid_i && arready_o |=> rd_pend_reg ##1 rvalid_o)
		else $error("Read data did not appear two cycles after the address.");

endmodule

// ==== rtl/pasl_top.sv ====
/*
 * Port analog select and output latch block with its AXI4-Lite register bank.
 * Assumes pin levels are already synchronous to clk_i and analog muxes sit outside.
 */
// Our own choices: the address map and the AXI4-Lite interface to the registers.
module pasl_top (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// AXI4-Lite write channels.
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	output logic [1:0]       bresp_o,
	// AXI4-Lite read channels.
	input  wire logic        arvalid_i,
	output logic             arready_o,
	input  wire logic [7:0]  araddr_i,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	// Port A pins.
	input  wire logic [7:0]  port_a_pins_i,
	output logic [7:0]       port_a_analog_o,
	output logic [7:0]       port_a_digital_o,
	// Port E pins.
	input  wire logic [7:0]  port_e_pins_i,
	output logic [7:0]       port_e_pins_o,
	output logic [7:0]       port_e_pins_oe_n_o,
	output logic [7:0]       port_e_analog_o,
	output logic [7:0]       port_e_digital_o
);

	pasl_regbus_if bus ();

	logic [7:0] ana_a_reg;
	logic [7:0] ana_e_reg;
	logic [7:0] dir_e_reg;
	logic [7:0] lat_e_reg;
	logic [7:0] pa_dig;
	logic [7:0] pe_dig;
	logic       wr_byte0;
	logic       hit_lat;
	logic       first_reg;
	logic       lat_known_reg;

	pasl_axil_slave u_slave (
		.clk_i     (clk_i),
		.nrst_i    (nrst_i),
		.awvalid_i (awvalid_i),
		.awready_o (awready_o),
		.awaddr_i  (awaddr_i),
		.wvalid_i  (wvalid_i),
		.wready_o  (wready_o),
		.wdata_i   (wdata_i),
		.wstrb_i   (wstrb_i),
		.bvalid_o  (bvalid_o),
		.bready_i  (bready_i),
		.bresp_o   (bresp_o),
		.arvalid_i (arvalid_i),
		.arready_o (arready_o),
		.araddr_i  (araddr_i),
		.rvalid_o  (rvalid_o),
		.rready_i  (rready_i),
		.rdata_o   (rdata_o),
		.rresp_o   (rresp_o),
		.bus       (bus.slave)
	);

	// Only the low byte carries register data, so only its strobe enables a store.
	assign wr_byte0 = bus.wr_en && bus.wr_strb[0];
	// The latch can be reached through the pin data address or its own address.
	assign hit_lat  = wr_byte0 && (bus.wr_addr == pasl_pkg::PASL_OFF_PE_PIN ||
		bus.wr_addr == pasl_pkg::PASL_OFF_PE_LAT);

	always_comb begin
		unique case (bus.wr_addr)
			pasl_pkg::PASL_OFF_ANA_A,
			pasl_pkg::PASL_OFF_PA_PIN,
			pasl_pkg::PASL_OFF_PE_PIN,
			pasl_pkg::PASL_OFF_PE_LAT,
			pasl_pkg::PASL_OFF_ANA_E,
			pasl_pkg::PASL_OFF_DIR_E: bus.wr_ok = 1'b1;
			default:                  bus.wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ana_a_reg <= pasl_pkg::PASL_ANA_A_RST;
		end else if (wr_byte0 && bus.wr_addr == pasl_pkg::PASL_OFF_ANA_A) begin
			ana_a_reg <= bus.wr_data[7:0] & pasl_pkg::PASL_ANA_A_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ana_e_reg <= pasl_pkg::PASL_ANA_E_RST;
		end else if (wr_byte0 && bus.wr_addr == pasl_pkg::PASL_OFF_ANA_E) begin
			ana_e_reg <= bus.wr_data[7:0] & pasl_pkg::PASL_ANA_E_MASK;
		end
	end

	// Pins start as inputs; software must keep analog pins as inputs as well.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dir_e_reg <= pasl_pkg::PASL_DIR_E_RST;
		end else if (wr_byte0 && bus.wr_addr == pasl_pkg::PASL_OFF_DIR_E) begin
			dir_e_reg <= bus.wr_data[7:0];
		end
	end

	// The latch has no reset on purpose, so it keeps its value across every reset.
	always_ff @(posedge clk_i) begin
		if (hit_lat) begin
			lat_e_reg <= bus.wr_data[7:0];
		end
	end

	// A disabled input buffer reads low, so an analog pin never toggles digital logic.
	assign pa_dig = port_a_pins_i & ~ana_a_reg;
	assign pe_dig = port_e_pins_i & ~ana_e_reg;

	assign port_a_analog_o    = ana_a_reg;
	assign port_a_digital_o   = pa_dig;
	assign port_e_analog_o    = ana_e_reg;
	assign port_e_digital_o   = pe_dig;
	assign port_e_pins_o      = lat_e_reg;
	assign port_e_pins_oe_n_o = dir_e_reg;

	always_comb begin
		bus.rd_ok   = 1'b1;
		bus.rd_data = 32'h0000_0000;
		unique case (bus.rd_addr)
			pasl_pkg::PASL_OFF_ANA_A:  bus.rd_data[7:0] = ana_a_reg;
			pasl_pkg::PASL_OFF_PA_PIN: bus.rd_data[7:0] = pa_dig;
			pasl_pkg::PASL_OFF_PE_PIN: bus.rd_data[7:0] = pe_dig;
			pasl_pkg::PASL_OFF_PE_LAT: bus.rd_data[7:0] = lat_e_reg;
			pasl_pkg::PASL_OFF_ANA_E:  bus.rd_data[7:0] = ana_e_reg;
			pasl_pkg::PASL_OFF_DIR_E:  bus.rd_data[7:0] = dir_e_reg;
			default:                   bus.rd_ok        = 1'b0;
		endcase
	end

	// Helpers read only by the checks below.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			first_reg <= 1'b1;
		end else begin
			first_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lat_known_reg <= 1'b0;
		end else if (hit_lat) begin
			lat_known_reg <= 1'b1;
		end
	end

	sequence lat_write_s;
		hit_lat ##0 bus.wr_addr == pasl_pkg::PASL_OFF_PE_PIN;
	endsequence

	sequence read_pins_e_s;
		arvalid_i && arready_o && araddr_i == pasl_pkg::PASL_OFF_PE_PIN;
	endsequence

	digital_route_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(port_a_digital_o & ~port_a_analog_o) == (port_a_pins_i & ~port_a_analog_o))
		else $error("A digital pin was not passed to port logic.");

	analog_block_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(port_a_digital_o & port_a_analog_o) == 8'h00)
		else $error("An analog pin reached the digital input path.");

	unimpl_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(port_a_analog_o & ~pasl_pkg::PASL_ANA_A_MASK) == 8'h00)
		else $error("An absent port A select bit became set.");

	reset_analog_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		first_reg |-> port_a_analog_o == pasl_pkg::PASL_ANA_A_RST)
		else $error("Port A selects were not all analog after reset.");

	latch_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		lat_write_s |=> port_e_pins_o == $past(bus.wr_data[7:0]))
		else $error("A port E data write did not land in the latch.");

	pin_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		read_pins_e_s ##1 $stable(pe_dig) |=> rdata_o[7:0] == $past(pe_dig))
		else $error("A port E data read did not return the pin levels.");

	latch_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		lat_known_reg && !hit_lat |=> $stable(port_e_pins_o))
		else $error("The port E latch changed without a write.");

	e_select_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(first_reg |-> port_e_analog_o == pasl_pkg::PASL_ANA_E_RST) and
		(port_e_digital_o == (port_e_pins_i & ~port_e_analog_o)))
		else $error("Port E select reset or gating is wrong.");

	e_unimpl_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(port_e_analog_o & ~pasl_pkg::PASL_ANA_E_MASK) == 8'h00)
		else $error("An absent port E select bit became set.");

endmodule

// ==== verification/pasl_pin_model.sv ====
/*
 * Far-side model of the package pins and the outside sources behind them.
 * Assumes an outside source drives a pin whenever the block leaves it undriven.
 */
module pasl_pin_model (
	// Outside source levels.
	input  wire logic [7:0] src_a_i,
	input  wire logic [7:0] src_e_i,
	// Block pin drivers.
	input  wire logic [7:0] drv_e_i,
	input  wire logic [7:0] oe_n_i,
	// Resolved pin levels.
	output logic      [7:0] pin_a_o,
	output logic      [7:0] pin_e_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Port A has no output drivers here, so the outside source always sets it.
	assign pin_a_o = src_a_i;
	// An input pin is left to the outside source; contention is not modelled.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_e_o[i] = oe_n_i[i] ? src_e_i[i] : drv_e_i[i];
		end
	end
endmodule

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the port select and latch block.
 * Assumes the pin model sits on the far side and the bench acts as bus master.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
	logic [7:0]  awaddr_i, araddr_i, src_a, src_e;
	logic [31:0] wdata_i;
	logic [3:0]  wstrb_i;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic [1:0]  bresp_o, rresp_o;
	logic [31:0] rdata_o;
	logic [7:0]  port_a_pins_i, port_a_analog_o, port_a_digital_o, port_e_pins_i;
	logic [7:0]  port_e_pins_o, port_e_pins_oe_n_o, port_e_analog_o, port_e_digital_o;
	int          err_total, n_tests, cyc;

	pasl_top DUT (.clk_i, .nrst_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o,
		.wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i,
		.rvalid_o, .rready_i, .rdata_o, .rresp_o, .port_a_pins_i, .port_a_analog_o,
		.port_a_digital_o, .port_e_pins_i, .port_e_pins_o, .port_e_pins_oe_n_o,
		.port_e_analog_o, .port_e_digital_o);
	pasl_pin_model pins (.src_a_i(src_a), .src_e_i(src_e), .drv_e_i(port_e_pins_o),
		.oe_n_i(port_e_pins_oe_n_o), .pin_a_o(port_a_pins_i), .pin_e_o(port_e_pins_i));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw, w, ta, tw, b;
		logic [1:0] rs;
		@(posedge clk_i);
		awvalid_i <= 1'b1;
		awaddr_i <= a;
		wvalid_i <= 1'b1;
		wdata_i <= {24'h000000, d};
		bready_i <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		while (aw || w) begin
			@(negedge clk_i);
			ta = awready_o;
			tw = wready_o;
			@(posedge clk_i);
			if (ta && aw) begin
				awvalid_i <= 1'b0;
				aw = 1'b0;
			end
			if (tw && w) begin
				wvalid_i <= 1'b0;
				w = 1'b0;
			end
		end
		while (!b) begin
			@(negedge clk_i);
			b = bvalid_o;
			rs = bresp_o;
			@(posedge clk_i);
		end
		bready_i <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, rs});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		logic t;
		logic [31:0] q;
		logic [1:0] rs;
		@(posedge clk_i);
		arvalid_i <= 1'b1;
		araddr_i <= a;
		rready_i <= 1'b1;
		t = 1'b0;
		while (!t) begin
			@(negedge clk_i);
			t = arready_o;
			@(posedge clk_i);
		end
		arvalid_i <= 1'b0;
		t = 1'b0;
		while (!t) begin
			@(negedge clk_i);
			t = rvalid_o;
			q = rdata_o;
			rs = rresp_o;
			@(posedge clk_i);
		end
		rready_i <= 1'b0;
		chk("rdata", {24'h000000, d}, q);
		chk("rresp", {30'h0, r}, {30'h0, rs});
	endtask

	task automatic t_reset;
		chk("latch", {24'h0, 8'hxx}, {24'h0, port_e_pins_o});
		chk("ana a", 32'h2f, {24'h0, port_a_analog_o});
		rd(pasl_pkg::PASL_OFF_ANA_A, 8'h2f, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_ANA_E, 8'h07, pasl_pkg::PASL_RESP_OKAY);
		$display("test reset done");
	endtask

	task automatic t_sel_a;
		wr(pasl_pkg::PASL_OFF_ANA_A, 8'hff, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_ANA_A, 8'h2f, pasl_pkg::PASL_RESP_OKAY);
		@(negedge clk_i);
		chk("dig a", 32'hd0, {24'h0, port_a_digital_o});
		rd(pasl_pkg::PASL_OFF_PA_PIN, 8'hd0, pasl_pkg::PASL_RESP_OKAY);
		wr(pasl_pkg::PASL_OFF_ANA_A, 8'h00, pasl_pkg::PASL_RESP_OKAY);
		@(negedge clk_i);
		chk("dig a", 32'hff, {24'h0, port_a_digital_o});
		chk("ana a", 32'h00, {24'h0, port_a_analog_o});
		rd(pasl_pkg::PASL_OFF_PA_PIN, 8'hff, pasl_pkg::PASL_RESP_OKAY);
		$display("test port a select done");
	endtask

	task automatic t_sel_e;
		wr(pasl_pkg::PASL_OFF_ANA_E, 8'hff, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_ANA_E, 8'h07, pasl_pkg::PASL_RESP_OKAY);
		@(negedge clk_i);
		chk("dig e", 32'h38, {24'h0, port_e_digital_o});
		chk("ana e", 32'h07, {24'h0, port_e_analog_o});
		wr(pasl_pkg::PASL_OFF_ANA_E, 8'h00, pasl_pkg::PASL_RESP_OKAY);
		@(negedge clk_i);
		chk("dig e", 32'h3c, {24'h0, port_e_digital_o});
		chk("ana e", 32'h00, {24'h0, port_e_analog_o});
		$display("test port e select done");
	endtask

	task automatic t_latch;
		wr(pasl_pkg::PASL_OFF_PE_PIN, 8'ha5, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_PE_LAT, 8'ha5, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_PE_PIN, 8'h3c, pasl_pkg::PASL_RESP_OKAY);
		wr(pasl_pkg::PASL_OFF_DIR_E, 8'h00, pasl_pkg::PASL_RESP_OKAY);
		@(negedge clk_i);
		chk("dir e", 32'h00, {24'h0, port_e_pins_oe_n_o});
		chk("pins e", 32'ha5, {24'h0, port_e_pins_o});
		rd(pasl_pkg::PASL_OFF_PE_PIN, 8'ha5, pasl_pkg::PASL_RESP_OKAY);
		$display("test latch done");
	endtask

	task automatic t_rst;
		// A second reset in mid-run must restore selects yet keep the latch.
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(negedge clk_i);
		chk("latch", 32'ha5, {24'h0, port_e_pins_o});
		rd(pasl_pkg::PASL_OFF_ANA_A, 8'h2f, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_ANA_E, 8'h07, pasl_pkg::PASL_RESP_OKAY);
		// A write without the low byte strobe must leave the register alone.
		wstrb_i <= 4'h0;
		wr(pasl_pkg::PASL_OFF_ANA_A, 8'h00, pasl_pkg::PASL_RESP_OKAY);
		wstrb_i <= 4'h1;
		rd(pasl_pkg::PASL_OFF_ANA_A, 8'h2f, pasl_pkg::PASL_RESP_OKAY);
		wr(pasl_pkg::PASL_OFF_PE_LAT, 8'h5a, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_PE_LAT, 8'h5a, pasl_pkg::PASL_RESP_OKAY);
		rd(pasl_pkg::PASL_OFF_PE_PIN, 8'h38, pasl_pkg::PASL_RESP_OKAY);
		wr(8'h1c, 8'hff, pasl_pkg::PASL_RESP_SLVERR);
		rd(8'h1c, 8'h00, pasl_pkg::PASL_RESP_SLVERR);
		$display("test reset and unmapped done");
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// The whole run needs about a hundred cycles; the ceiling leaves wide margin.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end

	initial begin
		{err_total, n_tests, cyc} = '0;
		{nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
		{awaddr_i, araddr_i, wdata_i} = '0;
		wstrb_i = 4'h1;
		src_a = 8'hff;
		src_e = 8'h3c;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_sel_a();
		t_sel_e();
		t_latch();
		t_rst();
		tally_and_finish();
	end
endmodule
